// >>> dtm_regs.vh
`ifndef DTM_REGS_VH
`define DTM_REGS_VH
// Behaviour
// - four speed grades; hit read 3-6T, bursts 3-2-2-2..6-5-5-5, writes 2-4T
// - RAS-to-CAS, CAS width, RAS and CAS precharge follow the grade
// - 32 size codes over 4 banks, densities 256K to 4M by N
// - two non-cacheable regions, size 64KB-4MB, start in regs 54-57
// - region match compares A23 down to the size bit only
// - inside an enabled region DRAM stays off, access goes to AT memory
// - overlap of DRAM and AT memory goes to DRAM when no region excludes
// - only on-board DRAM can be cacheable; AT memory never
// - bit 5 of reg 58 selects holding the CPU during refresh
// - without hold, a DRAM access waits until refresh ends
// - refresh RAS precharge 3,3,4,5T and active 3,4,4,5T per grade
// - local refresh runs on its own timer, apart from AT refresh
// - hidden AT refresh every 15us, only while the AT bus is idle
// - CPU AT cycle, DMA/master and AT refresh are arbitrated in turn
// - slow refresh mode cuts the local refresh rate to one quarter; AT refresh stays every 15us
// - refresh is CAS-before-RAS, all CAS one T ahead of any RAS
// - odd bank RAS follow even bank RAS by one T during refresh
// - shadow enable per 32KB block of C0000-EFFFF, one for F segment
// - shadow areas uncached except C0000-C7FFF and F segment when set
// - relocation moves A0000-BFFFF and D0000-EFFFF above DRAM top
// - relocation only for 1,2,4,6,8MB and D/E shadow off
// - ROM select for top 64/128KB below 1MB and below 4GB
// - with BIOS shadow on, BIOS accesses below 1MB go to DRAM

// register indices, byte address is four times the index
`define DTM_IDX_NC0_BASE 8'h54
`define DTM_IDX_NC0_CTRL 8'h55
`define DTM_IDX_NC1_BASE 8'h56
`define DTM_IDX_NC1_CTRL 8'h57
`define DTM_IDX_REFCFG   8'h58
`define DTM_IDX_DRAMCFG  8'h60
`define DTM_IDX_SHADOW   8'h61
`define DTM_IDX_MAP      8'h62
`define DTM_IDX_STATUS   8'h63
// field positions
`define DTM_NC_EN        7
`define DTM_REF_HOLD     5
`define DTM_REF_SLOW     0
`define DTM_REF_HIDDEN   1
`define DTM_DC_WR3       2
`define DTM_SH_F         6
`define DTM_SH_CCACHE    7
`define DTM_SH_FCACHE    8
`define DTM_MAP_RELOC    0
`define DTM_MAP_ROM128   1
// reset values
`define DTM_RST_REFCFG   8'h20
`define DTM_RST_DRAMCFG  8'h03
// 64KB segment numbers
`define DTM_SEG_A        16'h000a
`define DTM_SEG_C        16'h000c
`define DTM_SEG_D        16'h000d
`define DTM_SEG_E        16'h000e
`define DTM_SEG_F        16'h000f
`define DTM_SEG_TOPM1    16'hfffe
`define DTM_SEG_TOP      16'hffff
`define DTM_RELOC_SEGS   11'h004
// grade tables in half-T clocks, nibble 0 fastest
`define DTM_T_RCD        16'h6443
`define DTM_T_CAS        16'h6643
`define DTM_T_RP         16'h8866
`define DTM_T_CP         16'h4221
`define DTM_T_RD         16'hca86
`define DTM_T_BURST      16'ha864
`define DTM_T_WR2        16'h8444
`define DTM_T_WR3        16'h8664
`define DTM_T_RFPRE      16'ha866
`define DTM_T_RFACT      16'ha886
`define DTM_T_ONE        4'h2
`define DTM_BURST_LAST   2'h3
// timing
`define DTM_CLK_NS       10
`define DTM_REF_NS       15000
`define DTM_ATREF_NS     500
`define DTM_SLOW_MUL     4
`endif

// >>> dtm_ctrl.v
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "dtm_regs.vh"
module dtm_ctrl #(
    parameter REF_CYCLES   = `DTM_REF_NS / `DTM_CLK_NS,
    parameter SLOW_CYCLES  = REF_CYCLES * `DTM_SLOW_MUL,
    parameter ATREF_CYCLES = `DTM_ATREF_NS / `DTM_CLK_NS
) (
    input  wire        clock,
    input  wire        reset_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        memReq,
    input  wire        memWrite,
    input  wire        memBurst,
    input  wire [31:0] memAddr,
    output reg         memReady,
    output reg         cpuHold,
    output reg         dramSel,
    output reg         atSel,
    output reg         romCs,
    output reg         cacheable,
    output reg  [25:0] localAddr,
    output reg  [3:0]  rasN,
    output reg  [3:0]  casN,
    input  wire        cpuAtReq,
    input  wire        dmaReq,
    input  wire        masterReq,
    output reg         atGrantCpu,
    output reg         atGrantDma,
    output reg         atRefresh
);
// ----------------------------------------------------------------
// constants and helpers
// ----------------------------------------------------------------
localparam S_IDLE  = 3'd0;
localparam S_PRE   = 3'd1;
localparam S_RCD   = 3'd2;
localparam S_ACC   = 3'd3;
localparam S_RFCAS = 3'd4;
localparam S_RFRAS = 3'd5;
localparam S_RFPRE = 3'd6;
localparam O_NONE  = 2'd0;
localparam O_CPU   = 2'd1;
localparam O_DMA   = 2'd2;
localparam O_REF   = 2'd3;
function [3:0] tsel;
    input [15:0] tab;
    input [1:0]  g;
    begin
        tsel = tab[g*4 +: 4];
    end
endfunction

// 64KB units per bank for a density code, zero when unused
function [10:0] bankUnits;
    input [2:0] d;
    begin
        bankUnits = (d > 3'd4) ? 11'h000 : (11'h010 << d);
    end
endfunction

function ncMatch;
    input [7:0]  base;
    input [7:0]  ctrl;
    input [7:0]  a;
    reg   [7:0]  mask;
    begin
        mask = 8'hff << ctrl[2:0];
        ncMatch = ctrl[`DTM_NC_EN] && ctrl[2:0] < 3'd7
                  && ((a & mask) == (base & mask));
    end
endfunction

// ----------------------------------------------------------------
// registers and APB slave
// ----------------------------------------------------------------
reg [7:0] nc0Base_reg, nc0Ctrl_reg, nc1Base_reg, nc1Ctrl_reg;
reg [7:0] refCfg_reg, dramCfg_reg, map_reg;
reg [8:0] shadow_reg;
reg [2:0] state_reg;
reg       pageOpen_reg;
reg       relocOk;
wire [7:0] idx = paddr[9:2];
wire       setup = psel && !penable;
wire       wrEn = psel && penable && pready && pwrite;
reg [31:0] rdVal;
reg        hitIdx;

always @* begin
    hitIdx = 1'b1;
    rdVal = 32'h0;
    case (idx)
        `DTM_IDX_NC0_BASE: rdVal[7:0] = nc0Base_reg;
        `DTM_IDX_NC0_CTRL: rdVal[7:0] = nc0Ctrl_reg;
        `DTM_IDX_NC1_BASE: rdVal[7:0] = nc1Base_reg;
        `DTM_IDX_NC1_CTRL: rdVal[7:0] = nc1Ctrl_reg;
        `DTM_IDX_REFCFG:   rdVal[7:0] = refCfg_reg;
        `DTM_IDX_DRAMCFG:  rdVal[7:0] = dramCfg_reg;
        `DTM_IDX_SHADOW:   rdVal[8:0] = shadow_reg;
        `DTM_IDX_MAP:      rdVal[7:0] = map_reg;
        `DTM_IDX_STATUS:   rdVal[5:0] = {relocOk, pageOpen_reg,
                               cpuHold, state_reg};
        default:           hitIdx = 1'b0;
    endcase
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00)
        hitIdx = 1'b0;
end

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
        nc0Base_reg <= 8'h00;
        nc0Ctrl_reg <= 8'h00;
        nc1Base_reg <= 8'h00;
        nc1Ctrl_reg <= 8'h00;
        refCfg_reg <= `DTM_RST_REFCFG;
        dramCfg_reg <= `DTM_RST_DRAMCFG;
        shadow_reg <= 9'h000;
        map_reg <= 8'h00;
    end else begin
        pready <= 1'b1;
        if (setup) begin
            prdata <= hitIdx ? rdVal : 32'h0;
            pslverr <= !hitIdx;
        end
        if (wrEn && hitIdx) begin
            case (idx)
                `DTM_IDX_NC0_BASE: nc0Base_reg <= pwdata[7:0];
                `DTM_IDX_NC0_CTRL: nc0Ctrl_reg <= pwdata[7:0];
                `DTM_IDX_NC1_BASE: nc1Base_reg <= pwdata[7:0];
                `DTM_IDX_NC1_CTRL: nc1Ctrl_reg <= pwdata[7:0];
                `DTM_IDX_REFCFG:   refCfg_reg <= pwdata[7:0];
                `DTM_IDX_DRAMCFG:  dramCfg_reg <= pwdata[7:0];
                `DTM_IDX_SHADOW:   shadow_reg <= pwdata[8:0];
                `DTM_IDX_MAP:      map_reg <= pwdata[7:0];
                default:           map_reg <= map_reg;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// memory map routing
// ----------------------------------------------------------------
wire [1:0]  grade = dramCfg_reg[1:0];
wire [2:0]  dens = dramCfg_reg[7:5];
wire [10:0] bankSz = bankUnits(dens);
wire [12:0] topFull = {2'b00, bankSz} * ({11'h0, dramCfg_reg[4:3]} + 13'd1);
wire [10:0] top = topFull[10:0];
wire [15:0] seg = memAddr[31:16];
wire        deShadow = |shadow_reg[5:2];
reg         legacy, shadowOn, relocWin, romWin, toDram, cacheOk, ncHit;
reg  [25:0] locA;
reg  [2:0]  shIdx;
reg  [10:0] relOff;
reg  [15:0] relSeg;

always @* begin
    relocOk = map_reg[`DTM_MAP_RELOC] && !deShadow
              && (top == 11'h010 || top == 11'h020 || top == 11'h040
                  || top == 11'h060 || top == 11'h080);
    relOff = seg[10:0] - top;
    relocWin = relocOk && seg[15:11] == 5'h00 && seg[10:0] >= top
               && relOff < `DTM_RELOC_SEGS;
    legacy = seg >= `DTM_SEG_A && seg <= `DTM_SEG_F;
    shIdx = seg[2:0] - 3'd4;
    shIdx = {shIdx[1:0], memAddr[15]};
    shadowOn = (seg >= `DTM_SEG_C && seg < `DTM_SEG_F)
               ? shadow_reg[shIdx] : (seg == `DTM_SEG_F)
               && shadow_reg[`DTM_SH_F];
    romWin = seg == `DTM_SEG_F || seg == `DTM_SEG_TOP
             || (map_reg[`DTM_MAP_ROM128]
                 && (seg == `DTM_SEG_E || seg == `DTM_SEG_TOPM1));
    ncHit = ncMatch(nc0Base_reg, nc0Ctrl_reg, memAddr[23:16])
            || ncMatch(nc1Base_reg, nc1Ctrl_reg, memAddr[23:16]);
    if (ncHit)
        toDram = 1'b0;
    else if (relocWin)
        toDram = 1'b1;
    else if (legacy)
        toDram = shadowOn;
    else
        toDram = seg[15:11] == 5'h00 && seg[10:0] < top;
    cacheOk = !legacy
              || (seg == `DTM_SEG_C && !memAddr[15]
                  && shadow_reg[`DTM_SH_CCACHE])
              || (seg == `DTM_SEG_F && shadow_reg[`DTM_SH_FCACHE]);
    locA = memAddr[25:0];
    relSeg = (relOff[1] ? `DTM_SEG_D : `DTM_SEG_A) + {15'h0000, relOff[0]};
    if (relocWin)
        locA[25:16] = relSeg[9:0];
end

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        dramSel <= 1'b0;
        atSel <= 1'b0;
        romCs <= 1'b0;
        cacheable <= 1'b0;
        localAddr <= 26'h0;
    end else begin
        dramSel <= memReq && toDram;
        romCs <= memReq && romWin && !toDram && !ncHit;
        atSel <= memReq && !toDram && !(romWin && !ncHit);
        cacheable <= memReq && toDram && cacheOk;
        localAddr <= locA;
    end
end

// ----------------------------------------------------------------
// refresh timers
// ----------------------------------------------------------------
reg [12:0] refCnt_reg, atCnt_reg;
reg        refDue_reg, atDue_reg;
wire       slow = refCfg_reg[`DTM_REF_SLOW];
wire [12:0] refLim = slow ? SLOW_CYCLES[12:0] - 13'd1
                          : REF_CYCLES[12:0] - 13'd1;
wire        refTick = refCnt_reg >= refLim;
wire        atTick = atCnt_reg >= REF_CYCLES[12:0] - 13'd1;
wire        refStart = state_reg == S_IDLE && refDue_reg && !pageOpen_reg;
reg [1:0]   owner_reg;
reg [6:0]   atRefCnt_reg;
reg [1:0]   dmaSync_reg, mstSync_reg;
wire        busReq = dmaSync_reg[1] || mstSync_reg[1];
wire        atRefStart = owner_reg == O_NONE && atDue_reg
            && (!refCfg_reg[`DTM_REF_HIDDEN] || (!cpuAtReq && !busReq));

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        refCnt_reg <= 13'h0;
        atCnt_reg <= 13'h0;
        refDue_reg <= 1'b0;
        atDue_reg <= 1'b0;
    end else begin
        refCnt_reg <= refTick ? 13'h0 : refCnt_reg + 13'd1;
        atCnt_reg <= atTick ? 13'h0 : atCnt_reg + 13'd1;
        refDue_reg <= refTick || (refDue_reg && !refStart);
        atDue_reg <= atTick || (atDue_reg && !atRefStart);
    end
end

// ----------------------------------------------------------------
// AT bus arbiter
// ----------------------------------------------------------------
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        dmaSync_reg <= 2'b00;
        mstSync_reg <= 2'b00;
        owner_reg <= O_NONE;
        atRefCnt_reg <= 7'h0;
        atGrantCpu <= 1'b0;
        atGrantDma <= 1'b0;
        atRefresh <= 1'b0;
    end else begin
        dmaSync_reg <= {dmaSync_reg[0], dmaReq};
        mstSync_reg <= {mstSync_reg[0], masterReq};
        atGrantCpu <= 1'b0;
        atGrantDma <= 1'b0;
        atRefresh <= 1'b0;
        case (owner_reg)
            O_NONE: begin
                if (atRefStart) begin
                    owner_reg <= O_REF;
                    atRefCnt_reg <= ATREF_CYCLES[6:0];
                    atRefresh <= 1'b1;
                end else if (cpuAtReq) begin
                    owner_reg <= O_CPU;
                    atGrantCpu <= 1'b1;
                end else if (busReq) begin
                    owner_reg <= O_DMA;
                    atGrantDma <= 1'b1;
                end
            end
            O_CPU: begin
                atGrantCpu <= cpuAtReq;
                if (!cpuAtReq)
                    owner_reg <= O_NONE;
            end
            O_DMA: begin
                atGrantDma <= busReq;
                if (!busReq)
                    owner_reg <= O_NONE;
            end
            O_REF: begin
                atRefresh <= atRefCnt_reg > 7'd1;
                atRefCnt_reg <= atRefCnt_reg - 7'd1;
                if (atRefCnt_reg <= 7'd1)
                    owner_reg <= O_NONE;
            end
            default: owner_reg <= O_NONE;
        endcase
    end
end

// ----------------------------------------------------------------
// DRAM timing state machine
// ----------------------------------------------------------------
reg [3:0]  cnt_reg, cnt_next;
reg [2:0]  state_next;
reg [1:0]  bank_reg, bank_next, beat_reg, beat_next;
reg [14:0] row_reg, row_next;
reg        pageOpen_next, burst_reg, burst_next;
reg [3:0]  rasN_next, casN_next;
reg        ready_next;
wire [4:0] bShift = 5'd20 + {2'b00, dens};
wire [1:0] reqBank = memAddr[bShift +: 2];
wire [14:0] reqRow = memAddr[25:11];
wire       dramReq = memReq && dramSel && !memReady;
wire [3:0] accLen = memWrite ? (dramCfg_reg[`DTM_DC_WR3]
                                ? tsel(`DTM_T_WR3, grade)
                                : tsel(`DTM_T_WR2, grade))
                             : tsel(`DTM_T_RD, grade);
wire [3:0] rfAct = tsel(`DTM_T_RFACT, grade);

always @* begin
    state_next = state_reg;
    cnt_next = (cnt_reg > 4'd1) ? cnt_reg - 4'd1 : cnt_reg;
    bank_next = bank_reg;
    row_next = row_reg;
    beat_next = beat_reg;
    burst_next = burst_reg;
    pageOpen_next = pageOpen_reg;
    rasN_next = pageOpen_reg ? ~(4'b0001 << bank_reg) : 4'hf;
    casN_next = 4'hf;
    ready_next = 1'b0;
    case (state_reg)
        S_IDLE: begin
            if (refDue_reg && pageOpen_reg) begin
                state_next = S_PRE;
                cnt_next = tsel(`DTM_T_RP, grade);
                rasN_next = 4'hf;
            end else if (refStart) begin
                state_next = S_RFCAS;
                cnt_next = `DTM_T_ONE;
                casN_next = 4'h0;
            end else if (dramReq) begin
                bank_next = reqBank;
                row_next = reqRow;
                beat_next = 2'd0;
                burst_next = memBurst && !memWrite;
                if (pageOpen_reg && bank_reg == reqBank
                    && row_reg == reqRow) begin
                    state_next = S_ACC;
                    cnt_next = accLen;
                end else if (pageOpen_reg) begin
                    state_next = S_PRE;
                    cnt_next = tsel(`DTM_T_RP, grade);
                    rasN_next = 4'hf;
                end else begin
                    state_next = S_RCD;
                    cnt_next = tsel(`DTM_T_RCD, grade);
                    rasN_next = ~(4'b0001 << reqBank);
                    pageOpen_next = 1'b1;
                end
            end
        end
        S_PRE: begin
            rasN_next = 4'hf;
            pageOpen_next = 1'b0;
            if (cnt_reg == 4'd1)
                state_next = S_IDLE;
        end
        S_RCD: begin
            if (cnt_reg == 4'd1) begin
                state_next = S_ACC;
                cnt_next = accLen;
            end
        end
        S_ACC: begin
            if (cnt_next <= tsel(`DTM_T_CAS, grade)
                && cnt_reg > 4'd1)
                casN_next = 4'h0;
            ready_next = cnt_reg == 4'd2;
            if (cnt_reg == 4'd1) begin
                if (burst_reg && beat_reg != `DTM_BURST_LAST) begin
                    beat_next = beat_reg + 2'd1;
                    cnt_next = tsel(`DTM_T_BURST, grade);
                end else begin
                    state_next = S_IDLE;
                end
            end
        end
        S_RFCAS: begin
            casN_next = 4'h0;
            if (cnt_reg == 4'd1) begin
                state_next = S_RFRAS;
                cnt_next = rfAct + `DTM_T_ONE;
                rasN_next = 4'b1010;
            end
        end
        S_RFRAS: begin
            casN_next = 4'h0;
            rasN_next = (cnt_reg > rfAct + 4'd1) ? 4'b1010 : 4'h0;
            if (cnt_reg == 4'd1) begin
                state_next = S_RFPRE;
                cnt_next = tsel(`DTM_T_RFPRE, grade);
                rasN_next = 4'hf;
                casN_next = 4'hf;
            end
        end
        S_RFPRE: begin
            rasN_next = 4'hf;
            if (cnt_reg == 4'd1)
                state_next = S_IDLE;
        end
        default: state_next = S_IDLE;
    endcase
end

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        state_reg <= S_IDLE;
        cnt_reg <= 4'h0;
        bank_reg <= 2'd0;
        row_reg <= 15'h0;
        beat_reg <= 2'd0;
        burst_reg <= 1'b0;
        pageOpen_reg <= 1'b0;
        rasN <= 4'hf;
        casN <= 4'hf;
        memReady <= 1'b0;
        cpuHold <= 1'b0;
    end else begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        bank_reg <= bank_next;
        row_reg <= row_next;
        beat_reg <= beat_next;
        burst_reg <= burst_next;
        pageOpen_reg <= pageOpen_next;
        rasN <= rasN_next;
        casN <= casN_next;
        memReady <= ready_next;
        cpuHold <= refCfg_reg[`DTM_REF_HOLD]
                   && state_next >= S_RFCAS && state_next <= S_RFPRE;
    end
end

endmodule

// >>> dtm_ctrl_properties.sv
`timescale 1ns/10ps
// ----
// dram controller checks
// ----
module dtm_ctrl_properties #(
    parameter ATREF_CYCLES = 50
) (
    input logic       clock,
    input logic       reset_n,
    input logic       memReady,
    input logic       cpuHold,
    input logic       dramSel,
    input logic       atSel,
    input logic       romCs,
    input logic       cacheable,
    input logic [3:0] rasN,
    input logic [3:0] casN,
    input logic       atGrantCpu,
    input logic       atGrantDma,
    input logic       atRefresh
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    logic [15:0] refLen;
    always_ff @(posedge clock or negedge reset_n)
        if (!reset_n)
            refLen <= 16'h0000;
        else
            refLen <= atRefresh ? refLen + 16'h0001 : 16'h0000;
    a_cas_first: assert property (casN == 4'h0 && rasN == 4'hf &&
        $past(casN) != 4'h0 |=> casN == 4'h0 && rasN == 4'hf ##1
        rasN == 4'ha) else $error("ras before cas in refresh");
    a_odd_stagger: assert property (rasN == 4'ha &&
        $past(rasN) == 4'hf |=> rasN == 4'ha ##1 rasN == 4'h0)
        else $error("odd banks not one T late");
    a_ref_active: assert property (rasN == 4'h0 &&
        $past(rasN) == 4'ha |-> rasN == 4'h0 [*4])
        else $error("refresh ras active too short");
    a_ref_precharge: assert property (rasN == 4'hf &&
        $past(rasN) == 4'h0 |-> rasN == 4'hf [*6])
        else $error("refresh precharge too short");
    a_hold_ready: assert property (cpuHold |-> !memReady)
        else $error("ready while cpu held");
    a_ref_stall: assert property (casN == 4'h0 && rasN[1:0] == rasN[3:2]
        |-> !memReady) else $error("ready during refresh");
    a_ready_dram: assert property (memReady |-> dramSel)
        else $error("ready without dram route");
    a_at_uncached: assert property (atSel |-> !cacheable)
        else $error("at memory marked cacheable");
    a_route_excl: assert property ($onehot0({dramSel, atSel, romCs}))
        else $error("two routes at once");
    a_at_serial: assert property ($onehot0({atGrantCpu,
        atGrantDma, atRefresh})) else $error("two at bus owners");
    a_atref_len: assert property ($fell(atRefresh) |->
        refLen == ATREF_CYCLES) else $error("at refresh length");
    cover property ($rose(atRefresh));
    cover property ($rose(cpuHold));
    cover property (rasN == 4'ha);
endmodule
bind dtm_ctrl dtm_ctrl_properties #(.ATREF_CYCLES(ATREF_CYCLES)) chk (
    .clock(clock), .reset_n(reset_n), .memReady(memReady),
    .cpuHold(cpuHold), .dramSel(dramSel), .atSel(atSel), .romCs(romCs),
    .cacheable(cacheable), .rasN(rasN), .casN(casN),
    .atGrantCpu(atGrantCpu), .atGrantDma(atGrantDma),
    .atRefresh(atRefresh));

// >>> dtm_dram_model.sv
`timescale 1ns/10ps
// ----
// dram banks: count cas-before-ras refreshes
// ----
module dtm_dram_model (
    input  logic        clock,
    input  logic        reset_n,
    input  logic [3:0]  rasN,
    input  logic [3:0]  casN,
    output logic [15:0] refCount
);
    logic [3:0] casOld;
    always_ff @(posedge clock or negedge reset_n)
        if (!reset_n) begin
            refCount <= 16'h0000;
            casOld <= 4'hf;
        end else begin
            casOld <= casN;
            if (casN == 4'h0 && casOld != 4'h0 && rasN == 4'hf)
                refCount <= refCount + 16'h0001;
        end
endmodule

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
    logic        clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        memReq = 0, memWrite = 0, memBurst = 0, cpuAtReq = 0;
    logic        dmaReq = 0, masterReq = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, memAddr = 32'h0, prdata, rd;
    logic        pready, pslverr, memReady, cpuHold, dramSel, atSel;
    logic        romCs, cacheable, atGrantCpu, atGrantDma, atRefresh;
    logic [25:0] localAddr, seenLocal;
    logic [3:0]  rasN, casN;
    logic [15:0] refCount, rc0;
    int          bad_count = 0, n_tests = 0, lat, k;
    int RD[4] = '{6, 8, 10, 12};
    int WR[4] = '{4, 4, 4, 8};
    int BU[4] = '{18, 26, 34, 42};
    int RP[4] = '{6, 6, 8, 8};
    int RC[4] = '{3, 4, 4, 6};
    // ----
    // route table: index, data, address, {dram, at, rom, cache}
    // ----
    localparam logic [55:0] RT [20] = '{
        56'h00_000_00010000_9, 56'h00_000_000a0000_4,
        56'h00_000_000f0000_2, 56'h00_000_fffe0000_4,
        56'h00_000_ffff0000_2, 56'h00_000_00200000_4,
        56'h62_002_fffe0000_2, 56'h00_000_000e0000_2,
        56'h61_040_000f0000_8, 56'h61_140_000f0000_9,
        56'h61_0c1_000c0000_9, 56'h61_0c3_000c8000_8,
        56'h54_001_00020000_9, 56'h55_080_00010000_4,
        56'h00_000_00020000_9, 56'h55_081_00000000_4,
        56'h55_086_00050000_4, 56'h55_006_00050000_9,
        56'h57_080_00008000_4, 56'h57_000_00008000_9};
    always #5 clock = ~clock;
    dtm_ctrl #(.REF_CYCLES(300), .SLOW_CYCLES(1200), .ATREF_CYCLES(4)) uut (
        .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .memReq(memReq),
        .memWrite(memWrite), .memBurst(memBurst), .memAddr(memAddr),
        .memReady(memReady), .cpuHold(cpuHold), .dramSel(dramSel),
        .atSel(atSel), .romCs(romCs), .cacheable(cacheable),
        .localAddr(localAddr), .rasN(rasN), .casN(casN),
        .cpuAtReq(cpuAtReq), .dmaReq(dmaReq), .masterReq(masterReq),
        .atGrantCpu(atGrantCpu), .atGrantDma(atGrantDma),
        .atRefresh(atRefresh));
    dtm_dram_model dram (.clock(clock), .reset_n(reset_n), .rasN(rasN),
        .casN(casN), .refCount(refCount));
    task check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task hang(input int n);
        if (n >= 700) begin
            bad_count++;
            close_out;
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 700);
        hang(k);
        rd = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task mem(input logic [31:0] a, input logic w, b, input logic [3:0] r);
        int beats;
        @(posedge clock);
        memAddr <= a;
        memWrite <= w;
        memBurst <= b;
        memReq <= 1;
        @(posedge clock);
        #1 check("route", {dramSel, atSel, romCs, cacheable}, r);
        seenLocal = localAddr;
        lat = 0;
        beats = 0;
        while (dramSel === 1'b1 && beats < (b ? 4 : 1) && lat < 700) begin
            @(posedge clock);
            #1 lat++;
            if (memReady === 1'b1)
                beats++;
        end
        hang(lat);
        @(posedge clock);
        memReq <= 0;
    endtask
    task waitref(input logic [3:0] v);
        k = 0;
        while ((casN === 4'h0) !== v[0] && k < 700) begin
            @(posedge clock);
            #1 k++;
        end
        hang(k);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1;
        apb(0, 8'h58, 0);
        check("refcfg", rd, 32'h20);
        apb(0, 8'h60, 0);
        check("dramcfg", rd, 32'h03);
        apb(0, 8'h70, 0);
        check("unmapped", {pslverr, rd[30:0]}, 32'h80000000);
        foreach (RT[i]) begin
            if (RT[i][55:48] != 8'h00)
                apb(1, RT[i][55:48], {20'h0, RT[i][47:36]});
            mem(RT[i][35:4], 0, 0, RT[i][3:0]);
        end
        apb(1, 8'h61, 0);
        apb(1, 8'h62, 1);
        mem(32'h00100000, 0, 0, 4'h9);
        check("reloc_a", seenLocal, 32'h0a0000);
        mem(32'h00120000, 0, 0, 4'h9);
        check("reloc_d", seenLocal, 32'h0d0000);
        apb(1, 8'h61, 32'h4);
        mem(32'h00100000, 0, 0, 4'h4);
        apb(1, 8'h61, 0);
        apb(1, 8'h60, 32'h13);
        mem(32'h00300000, 0, 0, 4'h4);
        for (int g = 0; g < 4; g++) begin
            apb(1, 8'h60, g);
            waitref(1);
            waitref(0);
            mem(0, 0, 0, 4'h9);
            mem(0, 0, 0, 4'h9);
            check("read", lat, RD[g]);
            mem(0, 1, 0, 4'h9);
            check("write", lat, WR[g]);
            mem(0, 0, 1, 4'h9);
            check("burst", lat, BU[g]);
            mem(32'h80000, 0, 0, 4'h9);
            check("miss", lat, RP[g] + RC[g] + RD[g] + 1);
        end
        apb(1, 8'h60, 32'h5);
        mem(0, 0, 0, 4'h9);
        mem(0, 1, 0, 4'h9);
        check("write3", lat, 6);
        apb(1, 8'h60, 32'h3);
        waitref(1);
        repeat (2) @(posedge clock);
        #1 check("hold", cpuHold, 1);
        apb(1, 8'h58, 0);
        waitref(1);
        repeat (2) @(posedge clock);
        #1 check("nohold", cpuHold, 0);
        waitref(0);
        waitref(1);
        mem(0, 0, 0, 4'h9);
        check("stall", lat > RD[3], 1);
        rc0 = refCount;
        repeat (2400) @(posedge clock);
        check("rate", refCount - rc0 inside {[7:9]}, 1);
        apb(1, 8'h58, 1);
        rc0 = refCount;
        repeat (2400) @(posedge clock);
        check("slow", refCount - rc0 inside {[1:3]}, 1);
        cpuAtReq <= 1;
        repeat (8) @(posedge clock);
        #1 check("gcpu", atGrantCpu, 1);
        @(posedge clock);
        dmaReq <= 1;
        repeat (8) @(posedge clock);
        #1 check("gdmawait", atGrantDma, 0);
        @(posedge clock);
        cpuAtReq <= 0;
        repeat (8) @(posedge clock);
        #1 check("gdma", atGrantDma, 1);
        @(posedge clock);
        masterReq <= 1;
        dmaReq <= 0;
        repeat (8) @(posedge clock);
        #1 check("gmaster", atGrantDma, 1);
        apb(1, 8'h58, 2);
        k = 0;
        repeat (700) begin
            @(posedge clock);
            k += atRefresh;
        end
        check("hidden", k, 0);
        masterReq <= 0;
        k = 0;
        while (atRefresh !== 1'b1 && k < 700) begin
            @(posedge clock);
            k++;
        end
        check("hidfree", k < 700, 1);
        close_out;
    end
endmodule
